/* hdl/pcg_top.sv */
// Contract
// - Disable bit set stops clock, resets, blocks access.
// - Locked disable writes complete without error, unchanged.
// - Write lock is config control bit twelve.
// - Lock bit changes only after unlock sequence.
// - One-way option keeps a set lock set.
// - Only device reset clears a one-way lock.
// - Word one holds ADC, DACs, CTMU, EEPROM bits.
// - Word two holds comparators and op amps.
// - Word three holds capture and compare units.
// - Word four holds timers and PWM generators.
// - Word five holds UART, SPI, USB, CAN.
// - Word six holds refclocks, parallel port, encoders.
// - Word seven holds the DMA disable bit.
// - Write one disables, zero enables; reset zero.
`timescale 1ns/1ps
`default_nettype none
module pcg_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] i_boot_config_word3,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [223:0] o_clk_en,
    output logic [223:0] o_periph_rst,
    output logic [223:0] o_access_ok
);

    logic [31:0] module_disable_bits [0:6];
    logic [31:0] next_module_disable_bits [0:6];
    logic disable_write_lock;
    logic next_disable_write_lock;
    logic one_way_lock_option;
    logic next_one_way_lock_option;
    logic option_taken;
    logic next_option_taken;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup_phase;
    logic write_now;
    logic is_disable;
    logic is_config;
    logic is_key;
    logic is_status;
    logic mapped;
    logic [2:0] word_idx;
    logic key_wr;
    logic lock_consume;
    logic lock_block;
    logic unlocked;

    // Address decode for the word being addressed.
    always_comb begin
        word_idx = i_paddr[4:2];
        is_disable = 1'b0;
        is_config = 1'b0;
        is_key = 1'b0;
        is_status = 1'b0;
        if (i_paddr[1:0] != 2'b00) begin
            is_disable = 1'b0;
        end else if (i_paddr <= pcg_pkg::OFS_DISABLE7) begin
            is_disable = 1'b1;
        end else if (i_paddr == pcg_pkg::OFS_CONFIG_CONTROL) begin
            is_config = 1'b1;
        end else if (i_paddr == pcg_pkg::OFS_UNLOCK_KEY) begin
            is_key = 1'b1;
        end else if (i_paddr == pcg_pkg::OFS_LOCK_STATUS) begin
            is_status = 1'b1;
        end
        mapped = is_disable | is_config | is_key | is_status;
    end

    // A write lands only at the access edge, when pready is already high.
    assign setup_phase = i_psel & ~i_penable;
    assign write_now = i_psel & i_penable & o_pready & i_pwrite;
    assign key_wr = write_now & is_key;
    assign lock_consume = write_now & is_config;
    // A set lock under the one-way option shuts the key detector out.
    assign lock_block = one_way_lock_option & disable_write_lock;

    pcg_unlock u_unlock (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_key_wr(key_wr),
        .i_key_data(i_pwdata),
        .i_consume(lock_consume),
        .i_block(lock_block),
        .o_unlocked(unlocked)
    );

    // The option word is constant flash content, so it is taken once in the
    // first cycle after reset release and held until the next device reset.
    always_comb begin
        next_option_taken = 1'b1;
        next_one_way_lock_option = one_way_lock_option;
        if (!option_taken) begin
            next_one_way_lock_option =
                i_boot_config_word3[pcg_pkg::ONE_WAY_LOCK_OPTION_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            option_taken <= 1'b0;
            one_way_lock_option <= 1'b0;
        end else begin
            option_taken <= next_option_taken;
            one_way_lock_option <= next_one_way_lock_option;
        end
    end

    // Lock bit: changed only while the key sequence is open, and never
    // cleared again once set under the one-way option.
    always_comb begin
        next_disable_write_lock = disable_write_lock;
        if (lock_consume && unlocked) begin
            if (!(lock_block && !i_pwdata[pcg_pkg::DISABLE_WRITE_LOCK_BIT]))
            begin
                next_disable_write_lock =
                    i_pwdata[pcg_pkg::DISABLE_WRITE_LOCK_BIT];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            disable_write_lock <= 1'b0;
        end else begin
            disable_write_lock <= next_disable_write_lock;
        end
    end

    // Disable words: one next-value path per word, masked to the bits that
    // exist; a locked write is accepted on the bus but changes nothing.
    genvar gw;
    generate
        for (gw = 0; gw < pcg_pkg::NUM_WORDS; gw++) begin : g_word
            always_comb begin
                next_module_disable_bits[gw] = module_disable_bits[gw];
                if (write_now && is_disable && !disable_write_lock &&
                    word_idx == 3'(gw)) begin
                    next_module_disable_bits[gw] =
                        i_pwdata & pcg_pkg::DISABLE_MASK[gw];
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    module_disable_bits[gw] <= pcg_pkg::DISABLE_RESET;
                end else begin
                    module_disable_bits[gw] <= next_module_disable_bits[gw];
                end
            end

            pcg_gate_word u_gate (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_disable(module_disable_bits[gw]),
                .o_clk_en(o_clk_en[gw*32 +: 32]),
                .o_periph_rst(o_periph_rst[gw*32 +: 32]),
                .o_access_ok(o_access_ok[gw*32 +: 32])
            );
        end
    endgenerate

    // Bus answer: pready rises in the access cycle that follows every setup
    // cycle, so each transfer has no wait state. Read data is prepared in
    // the setup cycle and held through the access cycle.
    always_comb begin
        next_pready = setup_phase;
        next_pslverr = setup_phase & ~mapped;
        next_prdata = pcg_pkg::READ_ZERO;
        if (setup_phase && !i_pwrite) begin
            if (is_disable && word_idx < 3'd7) begin
                next_prdata = module_disable_bits[word_idx];
            end else if (is_config) begin
                next_prdata[pcg_pkg::DISABLE_WRITE_LOCK_BIT] =
                    disable_write_lock;
            end else if (is_status) begin
                next_prdata[pcg_pkg::STATUS_UNLOCKED_BIT] = unlocked;
                next_prdata[pcg_pkg::STATUS_ONE_WAY_BIT] =
                    one_way_lock_option;
                next_prdata[pcg_pkg::STATUS_LOCK_BIT] = disable_write_lock;
            end
        end else if (i_psel && i_penable && !o_pready) begin
            next_prdata = o_prdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= pcg_pkg::READ_ZERO;
        end else begin
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_prdata <= next_prdata;
        end
    end

    // Checks of the behaviour above.
    property p_locked_hold;
        @(posedge i_clk) disable iff (i_rst)
        (write_now && is_disable && disable_write_lock && word_idx == 3'd4)
        |=> (module_disable_bits[4] == $past(module_disable_bits[4]));
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("Locked disable word changed.");

    property p_locked_no_err;
        @(posedge i_clk) disable iff (i_rst)
        (setup_phase && is_disable && disable_write_lock) |=> !o_pslverr;
    endproperty
    a_locked_no_err: assert property (p_locked_no_err)
        else $error("Locked write answered with an error.");

    property p_unlocked_write;
        @(posedge i_clk) disable iff (i_rst)
        (write_now && is_disable && !disable_write_lock && word_idx == 3'd2)
        |=> (module_disable_bits[2] == $past(i_pwdata));
    endproperty
    a_unlocked_write: assert property (p_unlocked_write)
        else $error("Unlocked disable write lost.");

    property p_lock_needs_key;
        @(posedge i_clk) disable iff (i_rst)
        (lock_consume && !unlocked) |=> $stable(disable_write_lock);
    endproperty
    a_lock_needs_key: assert property (p_lock_needs_key)
        else $error("Lock bit changed without unlock sequence.");

    property p_one_way;
        @(posedge i_clk) disable iff (i_rst)
        (one_way_lock_option && disable_write_lock) |=> disable_write_lock;
    endproperty
    a_one_way: assert property (p_one_way)
        else $error("One-way lock was cleared.");

    property p_reset_clears;
        @(posedge i_clk)
        i_rst |=> (!disable_write_lock && module_disable_bits[0] == 32'h0);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("Reset left lock or disable bits set.");

    property p_gate_order;
        @(posedge i_clk) disable iff (i_rst)
        $rose(module_disable_bits[0][0]) && !i_rst ##1 !i_rst |->
        (o_periph_rst[0] && o_clk_en[0] && !o_access_ok[0])
        ##1 (!o_clk_en[0] || !module_disable_bits[0][0]);
    endproperty
    a_gate_order: assert property (p_gate_order)
        else $error("Clock stopped before reset reached peripheral.");

    property p_mask_word1;
        @(posedge i_clk) disable iff (i_rst)
        (module_disable_bits[0] & ~pcg_pkg::DISABLE_MASK[0]) == 32'h0;
    endproperty
    a_mask_word1: assert property (p_mask_word1)
        else $error("Unimplemented disable bit was set.");

    property p_bus_answer;
        @(posedge i_clk) disable iff (i_rst)
        setup_phase |=> (o_pready && o_pslverr == !$past(mapped));
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus answer missing or wrong.");

endmodule
`default_nettype wire

/* common/pcg_pkg.sv */
// Constants shared by the peripheral clock gate and write lock block.
`default_nettype none
package pcg_pkg;

    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int NUM_WORDS = 7;

    // Byte offsets of the register map.
    localparam logic [7:0] OFS_DISABLE1 = 8'h00;
    localparam logic [7:0] OFS_DISABLE7 = 8'h18;
    localparam logic [7:0] OFS_CONFIG_CONTROL = 8'h1C;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h20;
    localparam logic [7:0] OFS_LOCK_STATUS = 8'h24;

    // Field positions.
    localparam int DISABLE_WRITE_LOCK_BIT = 12;
    localparam int ONE_WAY_LOCK_OPTION_BIT = 28;
    localparam int STATUS_UNLOCKED_BIT = 0;
    localparam int STATUS_ONE_WAY_BIT = 1;
    localparam int STATUS_LOCK_BIT = 2;

    // Named disable bit positions of the peripherals.
    localparam int ADC_GROUP_DISABLE = 0;
    localparam int CDAC_ONE_DISABLE = 4;
    localparam int CHARGE_TIME_UNIT_DISABLE = 8;
    localparam int DATA_EEPROM_DISABLE = 9;
    localparam int OPAMP_ONE_DISABLE = 16;
    localparam int COMPARE_ONE_DISABLE = 16;
    localparam int PWM_ONE_DISABLE = 16;
    localparam int USB_ONE_DISABLE = 24;
    localparam int CAN_ONE_DISABLE = 28;
    localparam int REFCLK_ONE_DISABLE = 8;
    localparam int PARALLEL_PORT_DISABLE = 16;
    localparam int DMA_DISABLE_BIT = 4;

    // Implemented bits of each disable word; the rest read as zero.
    localparam logic [31:0] DISABLE_MASK [0:NUM_WORDS-1] = '{
        32'h0000_0371,
        32'h0017_001F,
        32'hFFFF_FFFF,
        32'h0FFF_01FF,
        32'hF300_3F3F,
        32'h0F0D_0F00,
        32'h0000_0010
    };

    // Reset values.
    localparam logic [31:0] DISABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Two key words that must be written back to back to unlock.
    localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;

    // Unlock sequence states.
    typedef enum logic [1:0] {
        PCG_KEY_IDLE,
        PCG_KEY_HALF,
        PCG_KEY_OPEN
    } pcg_key_state_t;

endpackage
`default_nettype wire

/* hdl/pcg_unlock.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-word key detector that opens one change of the write lock bit.
module pcg_unlock (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_key_wr,
    input wire logic [31:0] i_key_data,
    input wire logic i_consume,
    input wire logic i_block,
    output logic o_unlocked
);

    pcg_pkg::pcg_key_state_t state;
    pcg_pkg::pcg_key_state_t next_state;

    // Any wrong key restarts the sequence, and a lock write uses it up.
    always_comb begin
        next_state = state;
        if (i_block) begin
            next_state = pcg_pkg::PCG_KEY_IDLE;
        end else if (i_consume) begin
            next_state = pcg_pkg::PCG_KEY_IDLE;
        end else if (i_key_wr) begin
            case (state)
                pcg_pkg::PCG_KEY_IDLE: begin
                    if (i_key_data == pcg_pkg::UNLOCK_KEY1) begin
                        next_state = pcg_pkg::PCG_KEY_HALF;
                    end
                end
                pcg_pkg::PCG_KEY_HALF: begin
                    if (i_key_data == pcg_pkg::UNLOCK_KEY2) begin
                        next_state = pcg_pkg::PCG_KEY_OPEN;
                    end else begin
                        next_state = pcg_pkg::PCG_KEY_IDLE;
                    end
                end
                default: begin
                    next_state = pcg_pkg::PCG_KEY_IDLE;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= pcg_pkg::PCG_KEY_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign o_unlocked = (state == pcg_pkg::PCG_KEY_OPEN);

endmodule
`default_nettype wire

/* hdl/pcg_gate_word.sv */
`timescale 1ns/1ps
`default_nettype none
// Clock enable, reset and access qualifier for 32 peripherals.
module pcg_gate_word (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [31:0] i_disable,
    output logic [31:0] o_clk_en,
    output logic [31:0] o_periph_rst,
    output logic [31:0] o_access_ok
);

    logic [31:0] next_clk_en;
    logic [31:0] next_periph_rst;
    logic [31:0] next_access_ok;

    // On disable the reset rises one cycle before the clock stops, so the
    // peripheral registers see a clock edge under reset. All enables change
    // only at the rising edge, so an integrating gate cell latching them in
    // the low phase never cuts a clock pulse short.
    always_comb begin
        next_periph_rst = i_disable;
        next_clk_en = ~(i_disable & o_periph_rst);
        next_access_ok = ~i_disable & ~o_periph_rst;
    end

    // Registered outputs.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clk_en <= 32'hFFFF_FFFF;
            o_periph_rst <= 32'h0000_0000;
            o_access_ok <= 32'hFFFF_FFFF;
        end else begin
            o_clk_en <= next_clk_en;
            o_periph_rst <= next_periph_rst;
            o_access_ok <= next_access_ok;
        end
    end

endmodule
`default_nettype wire

/* tb/pcg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    num_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end end

module pcg_top_tb;
    logic i_clk;
    logic i_rst;
    logic i_psel;
    logic i_penable;
    logic i_pwrite;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] i_boot_config_word3;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [223:0] o_clk_en;
    logic [223:0] o_periph_rst;
    logic [223:0] o_access_ok;
    logic [33:0] notes [$];
    logic [33:0] note;
    logic [31:0] shadow [0:6];
    logic [31:0] rnd;
    int num_errors = 0;
    int n_tests = 0;
    int seed_val;

    pcg_top pcg_top_i (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_boot_config_word3(i_boot_config_word3),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .o_clk_en(o_clk_en),
        .o_periph_rst(o_periph_rst),
        .o_access_ok(o_access_ok)
    );

    // Free running 25 MHz system clock.
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Every completed transfer takes the oldest note; notes with bit 33 set also check data.
    always @(posedge i_clk) begin
        if (i_psel && i_penable && o_pready === 1'b1) begin
            note = notes.pop_front();
            if (note[33]) begin
                `CHK({o_pslverr, o_prdata}, note[32:0])
            end else begin
                `CHK(o_pslverr, note[32])
            end
        end
    end

    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One APB transfer; it waits for pready as long as the slave needs.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] exp);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        notes.push_back(exp);
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Only the watchdog ends a wait for a slave that never answers.
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {2'b10, e});
    endtask

    function automatic logic [7:0] dis_addr(input int w);
        return pcg_pkg::OFS_DISABLE1 + 8'(4 * w);
    endfunction

    task automatic unlock();
        wr(pcg_pkg::OFS_UNLOCK_KEY, pcg_pkg::UNLOCK_KEY1);
        wr(pcg_pkg::OFS_UNLOCK_KEY, pcg_pkg::UNLOCK_KEY2);
    endtask

    // Reset also clears the model, since the design forgets everything.
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int w = 0; w < 7; w++) shadow[w] = 32'h0000_0000;
    endtask

    // Settled gating outputs must mirror the disable words bit for bit.
    task automatic check_gate();
        logic [223:0] dis;
        for (int w = 0; w < 7; w++) dis[w*32 +: 32] = shadow[w];
        repeat (3) @(posedge i_clk);
        `CHK(o_clk_en, ~dis)
        `CHK(o_periph_rst, dis)
        `CHK(o_access_ok, ~dis)
    endtask

    // Hang guard; the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        i_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        i_boot_config_word3 = 32'h0000_0000;
        seed_val = $urandom(32'haa91);
        do_reset();
        for (int w = 0; w < 7; w++) rd(dis_addr(w), 32'h0000_0000);
        rd(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0000);
        check_gate();
        // Random words land only on implemented disable bits. No peripheral
        // is switched on or busy here, so any disable bit may be set.
        for (int w = 0; w < 7; w++) begin
            rnd = $urandom();
            wr(dis_addr(w), rnd);
            shadow[w] = rnd & pcg_pkg::DISABLE_MASK[w];
            rd(dis_addr(w), shadow[w]);
        end
        check_gate();
        for (int w = 0; w < 7; w++) wr(dis_addr(w), 32'h0000_0000);
        for (int w = 0; w < 7; w++) shadow[w] = 32'h0000_0000;
        // Reset rises before the clock stops, so no clipped pulse occurs.
        wr(pcg_pkg::OFS_DISABLE1, 32'h0000_0001);
        repeat (2) @(posedge i_clk);
        `CHK({o_periph_rst[0], o_clk_en[0]}, 2'b11)
        @(posedge i_clk);
        `CHK(o_clk_en[0], 1'b0)
        wr(pcg_pkg::OFS_DISABLE1, 32'h0000_0000);
        // A lock change without the key is ignored, and a broken key sequence does not unlock.
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_1000);
        rd(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        wr(pcg_pkg::OFS_UNLOCK_KEY, pcg_pkg::UNLOCK_KEY1);
        wr(pcg_pkg::OFS_UNLOCK_KEY, 32'h1234_5678);
        wr(pcg_pkg::OFS_UNLOCK_KEY, pcg_pkg::UNLOCK_KEY2);
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0000);
        unlock();
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0001);
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_1000);
        rd(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_1000);
        wr(dis_addr(4), 32'hFFFF_FFFF);
        rd(dis_addr(4), 32'h0000_0000);
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0004);
        unlock();
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        wr(dis_addr(6), 32'h0000_0010);
        shadow[6] = 32'h0000_0010;
        rd(dis_addr(6), 32'h0000_0010);
        apb(1'b0, 8'h28, 32'h0000_0000, {2'b01, 32'h0000_0000});
        apb(1'b1, 8'h02, 32'h0000_0001, {2'b01, 32'h0000_0000});
        check_gate();
        // One-way option: once set, the lock holds until a device reset.
        i_boot_config_word3 <= $urandom() | 32'h1000_0000;
        do_reset();
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0002);
        unlock();
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_1000);
        unlock();
        rd(pcg_pkg::OFS_LOCK_STATUS, 32'h0000_0006);
        wr(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        rd(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_1000);
        wr(pcg_pkg::OFS_DISABLE1, 32'h0000_0001);
        rd(pcg_pkg::OFS_DISABLE1, 32'h0000_0000);
        do_reset();
        rd(pcg_pkg::OFS_CONFIG_CONTROL, 32'h0000_0000);
        wr(pcg_pkg::OFS_DISABLE1, 32'h0000_0371);
        shadow[0] = 32'h0000_0371;
        rd(pcg_pkg::OFS_DISABLE1, 32'h0000_0371);
        check_gate();
        report_and_stop();
    end
endmodule
`default_nettype wire
